// *** shared/dra_defines.svh ***
`ifndef DRA_DEFINES_SVH
`define DRA_DEFINES_SVH

// ============================================================
// timing
`define DRA_CLK_NS 10
`define DRA_HOLD_NS 50
`define DRA_HOLD_CYC ((`DRA_HOLD_NS + `DRA_CLK_NS - 1) / `DRA_CLK_NS)
`define DRA_MEM_CYCLE_NS 400
`define DRA_MEM_CYC ((`DRA_MEM_CYCLE_NS + `DRA_CLK_NS - 1) / `DRA_CLK_NS)
`define DRA_BURST_PERIOD_NS 2000000
`define DRA_BURST_CYC (`DRA_BURST_PERIOD_NS / `DRA_CLK_NS)
`define DRA_ROWS 64

// ============================================================
// widths
`define DRA_ADDR_W 6
`define DRA_CNT_W 6
`define DRA_TMR_W 18
`define DRA_LEFT_W 7

`endif

// *** shared/dra_pkg.sv ***
package dra_pkg;
    typedef enum logic [3:0] {
        DRA_IDLE = 4'b0001,
        DRA_HOLD = 4'b0010,
        DRA_CYCLE = 4'b0100,
        DRA_DONE = 4'b1000
    } dra_state_t;
    typedef logic [5:0] dra_addr_t;
endpackage

// *** verilog/dra_host_ctrl.sv ***
// How it works
// RULE_01: device grants refresh only when idle, first
// RULE_02: device grants system cycle when idle, first
// RULE_03: latch output fed back or driven externally
// RULE_04: device start output announces a cycle
// RULE_05: device outputs system or refresh address
// RULE_06: busy high means idle, low means cycle
// RULE_07: refresh-active low for refresh cycle
// RULE_08: acknowledge low for granted system cycle
// RULE_09: busy held low for whole memory cycle
// RULE_10: start edge sets busy, then launches timing
// RULE_11: busy fall ends start, then acknowledge
// RULE_12: drop cycle request before busy rises
// RULE_13: idle device passes system address through
// RULE_14: device delays start until busy rises
// RULE_15: refresh-active and acknowledge never together
// RULE_16: refresh start drives start and refresh-active
// RULE_17: queued refresh starts after busy rises
// RULE_18: simultaneous requests resolved to exactly one
// RULE_19: burst mode issues 64 refreshes per 2ms
// RULE_20: internal oscillator sets distributed interval
// RULE_21: at least 50 ns start fall to busy fall
// RULE_22: refresh row counter advances and wraps
`include "dra_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module dra_host_ctrl #(
    parameter int BURST_PERIOD_CYC = `DRA_BURST_CYC
) (
    input wire logic core_clk,
    input wire logic reset,
    // cpu side
    input wire logic cpuReq,
    input wire dra_pkg::dra_addr_t cpuAddr,
    input wire logic refreshInternal,
    output logic cpuReady,
    output logic cpuDone,
    // controller pins
    input wire logic start_cycle_n,
    input wire logic refresh_active_n,
    input wire logic ack_n,
    input wire logic refresh_latch_n,
    input wire dra_pkg::dra_addr_t mem_addr_out_n,
    output logic refresh_request_n,
    output logic cycle_request_n,
    output logic busy,
    output dra_pkg::dra_addr_t sys_addr_low,
    // memory timing side
    output logic memTimingStart,
    output logic memCycleRefresh,
    output dra_pkg::dra_addr_t memRowAddr,
    output logic burstActive
);
    import dra_pkg::*;

    // ========================================================
    // state and registers
    dra_state_t state_reg, state_next;
    logic [`DRA_CNT_W-1:0] cnt_reg;
    logic pend_reg;
    logic drop_reg;
    dra_addr_t addr_reg;
    logic busy_reg;
    logic launch_reg;
    logic done_reg;
    logic kind_reg;
    dra_addr_t row_reg;
    logic [`DRA_TMR_W-1:0] tmr_reg;
    logic [`DRA_LEFT_W-1:0] left_reg;
    logic [`DRA_LEFT_W-1:0] left_next;

    // ========================================================
    // decode
    wire logic startSeen = !start_cycle_n;
    wire logic holdEnd = (cnt_reg == `DRA_CNT_W'(`DRA_HOLD_CYC - 1));
    wire logic cycEnd = (cnt_reg == `DRA_CNT_W'(`DRA_MEM_CYC - 1));
    wire logic lastCyc = (state_reg == DRA_CYCLE) && cycEnd;
    wire logic sysGranted = lastCyc && !ack_n;
    wire logic refGranted = lastCyc && !refresh_active_n;
    wire logic burstTick = (tmr_reg == `DRA_TMR_W'(BURST_PERIOD_CYC - 1));
    wire logic burstReq = (left_reg != `DRA_LEFT_W'(0));

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            DRA_IDLE: begin
                // start fall sets the busy latch after hold
                if (startSeen) begin
                    state_next = DRA_HOLD; // [RULE_10]
                end
            end
            DRA_HOLD: begin
                if (holdEnd) begin
                    state_next = DRA_CYCLE; // [RULE_21]
                end
            end
            DRA_CYCLE: begin
                if (cycEnd) begin
                    state_next = DRA_DONE; // [RULE_09]
                end
            end
            DRA_DONE: state_next = DRA_IDLE;
            default: state_next = DRA_IDLE;
        endcase
    end

    // a new burst restarts the row count; else one per refresh
    always_comb begin
        left_next = left_reg;
        if (burstTick && !refreshInternal) begin
            left_next = `DRA_LEFT_W'(`DRA_ROWS); // [RULE_19]
        end else if (refGranted && burstReq) begin
            left_next = left_reg - `DRA_LEFT_W'(1);
        end
    end

    // ========================================================
    // sequencing
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_reg <= DRA_IDLE;
            cnt_reg <= '0;
        end else begin
            state_reg <= state_next;
            if (state_next != state_reg) begin
                cnt_reg <= '0;
            end else begin
                cnt_reg <= cnt_reg + `DRA_CNT_W'(1);
            end
        end
    end

    // busy stays low through the full cycle
    always_ff @(posedge core_clk) begin
        if (reset) begin
            busy_reg <= 1'b1;
            launch_reg <= 1'b0;
        end else begin
            busy_reg <= (state_next != DRA_CYCLE); // [RULE_09]
            launch_reg <= (state_reg == DRA_HOLD) && holdEnd; // [RULE_10]
        end
    end

    // cpu request held until the controller grants it
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pend_reg <= 1'b0;
            addr_reg <= '0;
        end else if (sysGranted) begin
            pend_reg <= 1'b0; // [RULE_12]
        end else if (cpuReq && !pend_reg) begin
            pend_reg <= 1'b1;
            addr_reg <= cpuAddr;
        end
    end

    // release the request once the cycle is ours, well ahead of busy
    // rising; dropping it on the same edge as busy would be a race
    always_ff @(posedge core_clk) begin
        if (reset) begin
            drop_reg <= 1'b0;
        end else if (sysGranted) begin
            drop_reg <= 1'b0;
        end else if (state_reg == DRA_CYCLE && !ack_n) begin
            drop_reg <= 1'b1; // [RULE_12]
        end
    end

    // result of the finished cycle
    always_ff @(posedge core_clk) begin
        if (reset) begin
            done_reg <= 1'b0;
            kind_reg <= 1'b0;
            row_reg <= '0;
        end else begin
            done_reg <= sysGranted;
            if (lastCyc) begin
                kind_reg <= !refresh_active_n;
                // outputs are inverted toward the array
                row_reg <= ~mem_addr_out_n;
            end
        end
    end

    // burst refresh scheduler, unused in oscillator mode
    always_ff @(posedge core_clk) begin
        if (reset) begin
            tmr_reg <= '0;
            left_reg <= '0;
        end else begin
            tmr_reg <= burstTick ? '0 : tmr_reg + `DRA_TMR_W'(1);
            left_reg <= left_next;
        end
    end

    // ========================================================
    // outputs
    assign busy = busy_reg;
    assign cycle_request_n = !(pend_reg && !drop_reg); // [RULE_12]
    assign sys_addr_low = addr_reg;
    // oscillator mode: latch output loops straight back
    assign refresh_request_n = refreshInternal ? refresh_latch_n
        : !burstReq; // [RULE_03]
    assign cpuReady = !pend_reg;
    assign cpuDone = done_reg;
    assign memTimingStart = launch_reg;
    assign memCycleRefresh = kind_reg;
    assign memRowAddr = row_reg;
    assign burstActive = burstReq;

    // ========================================================
    // checks
    logic [`DRA_CNT_W:0] lowLen_reg;
    always_ff @(posedge core_clk) begin
        if (reset || busy) begin
            lowLen_reg <= '0;
        end else begin
            lowLen_reg <= lowLen_reg + (`DRA_CNT_W+1)'(1);
        end
    end

    start_hold_gap_a: // [RULE_21]
    assert property (@(posedge core_clk) disable iff (reset)
        (state_reg == DRA_IDLE && !start_cycle_n) |-> busy[*5])
        else $error("busy fell too soon after start");

    busy_full_len_a: // [RULE_09]
    assert property (@(posedge core_clk) disable iff (reset)
        $rose(busy) |->
            lowLen_reg == (`DRA_CNT_W+1)'(`DRA_MEM_CYC))
        else $error("busy low time wrong");

    request_release_a: // [RULE_12]
    assert property (@(posedge core_clk) disable iff (reset)
        sysGranted |-> cycle_request_n && !busy ##1 busy)
        else $error("cycle request not dropped before busy rise");

    timing_launch_a: // [RULE_10]
    assert property (@(posedge core_clk) disable iff (reset)
        $fell(busy) |-> memTimingStart ##1 !memTimingStart)
        else $error("timing not launched with busy fall");

    latch_feedback_a: // [RULE_03]
    assert property (@(posedge core_clk) disable iff (reset)
        refreshInternal |-> refresh_request_n == refresh_latch_n)
        else $error("latch output not fed back");

    burst_load_a: // [RULE_19]
    assert property (@(posedge core_clk) disable iff (reset)
        (burstTick && !refreshInternal) |=>
            left_reg == `DRA_LEFT_W'(`DRA_ROWS) && !refresh_request_n)
        else $error("burst did not load 64 refreshes");

    burst_gate_a: // [RULE_19]
    assert property (@(posedge core_clk) disable iff (reset)
        (!refreshInternal && !refresh_request_n) |-> burstReq)
        else $error("refresh requested with no burst left");

    cpu_done_a: // [RULE_12]
    assert property (@(posedge core_clk) disable iff (reset)
        cpuDone |-> !$past(ack_n) && !memCycleRefresh)
        else $error("done without a granted system cycle");

    addr_steady_a: // [RULE_12]
    assert property (@(posedge core_clk) disable iff (reset)
        (pend_reg && $past(pend_reg)) |->
            $stable(sys_addr_low))
        else $error("address moved under a pending request");
endmodule

`default_nettype wire

// *** tb/dra_ctrl_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module dra_ctrl_model #(
    parameter int OSC_CYC = 300
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic refresh_request_n,
    input wire logic cycle_request_n,
    input wire logic busy,
    input wire dra_pkg::dra_addr_t sys_addr_low,
    output logic start_cycle_n,
    output logic refresh_active_n,
    output logic ack_n,
    output var logic refresh_latch_n,
    output dra_pkg::dra_addr_t mem_addr_out_n
);
    import dra_pkg::*;
    logic sysGo_reg, refGo_reg, seen_reg;
    dra_addr_t row_reg;
    int osc_reg;
    // ==========================================
    // grant decode
    wire granted = sysGo_reg || refGo_reg;
    wire idle = busy && !granted;
    // start falls on grant and rises once busy has been seen low
    assign start_cycle_n = !(granted && busy && !seen_reg);
    assign refresh_active_n = !refGo_reg;
    assign ack_n = !(sysGo_reg && !busy);
    assign mem_addr_out_n = (refGo_reg && !busy) ? ~row_reg
        : ~sys_addr_low;
    // ==========================================
    // arbitration latch and oscillator
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sysGo_reg <= 1'b0;
            refGo_reg <= 1'b0;
            seen_reg <= 1'b0;
            row_reg <= '0;
            osc_reg <= 0;
            refresh_latch_n <= 1'b1;
        end else begin
            // refresh wins a tie, the other request waits
            if (idle && !refresh_request_n) begin
                refGo_reg <= 1'b1;
                refresh_latch_n <= 1'b1;
            end else if (idle && !cycle_request_n) begin
                sysGo_reg <= 1'b1;
            end
            osc_reg <= (osc_reg == OSC_CYC - 1) ? 0 : osc_reg + 1;
            if (osc_reg == OSC_CYC - 1) begin
                refresh_latch_n <= 1'b0;
            end
            if (!busy) begin
                seen_reg <= 1'b1;
            end
            if (busy && seen_reg) begin
                seen_reg <= 1'b0;
                sysGo_reg <= 1'b0;
                refGo_reg <= 1'b0;
                row_reg <= row_reg + (refGo_reg ? 6'h1 : 6'h0);
            end
        end
    end
endmodule
`default_nettype wire

// *** tb/test_dram_refresh_arbiter.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_dram_refresh_arbiter;
    import dra_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic cpuReq = 1'b0;
    logic refreshInternal = 1'b0;
    dra_addr_t cpuAddr = '0;
    logic cpuReady, cpuDone, start_cycle_n, refresh_active_n, ack_n;
    logic refresh_latch_n, refresh_request_n, cycle_request_n, busy;
    logic memTimingStart, memCycleRefresh, burstActive;
    dra_addr_t mem_addr_out_n, sys_addr_low, memRowAddr, row, prev;
    int fail_count = 0;
    int n_compared = 0;
    always #5 core_clk = ~core_clk;
    dra_host_ctrl #(.BURST_PERIOD_CYC(5000)) dra_host_ctrl_i (.core_clk,
        .reset, .cpuReq, .cpuAddr, .refreshInternal, .cpuReady, .cpuDone,
        .start_cycle_n, .refresh_active_n, .ack_n, .refresh_latch_n,
        .mem_addr_out_n, .refresh_request_n, .cycle_request_n, .busy,
        .sys_addr_low, .memTimingStart, .memCycleRefresh, .memRowAddr,
        .burstActive);
    dra_ctrl_model dra_ctrl_model_i (.core_clk, .reset, .refresh_request_n,
        .cycle_request_n, .busy, .sys_addr_low, .start_cycle_n,
        .refresh_active_n, .ack_n, .refresh_latch_n, .mem_addr_out_n);
    // ==========================================
    // shared tasks
    task automatic check(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s: expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("compared %0d wrong %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic issue(input dra_addr_t a);
        @(posedge core_clk);
        cpuReq <= 1'b1;
        cpuAddr <= a;
        @(posedge core_clk);
        cpuReq <= 1'b0;
    endtask
    task automatic run_cycle(input logic isRef, output dra_addr_t rowSeen);
        int n;
        realtime t0;
        n = 0;
        while (start_cycle_n !== 1'b0 && n < 9000) begin
            @(negedge core_clk);
            n++;
        end
        t0 = $realtime;
        n = 0;
        while (busy !== 1'b0 && n < 20) begin
            @(negedge core_clk);
            n++;
        end
        check("hold", 1, ($realtime - t0) >= 50.0);
        check("launch", 1, memTimingStart);
        n = 0;
        while (busy === 1'b0 && n < 99) begin
            if (n == 20) begin
                check("refresh on", !isRef, refresh_active_n);
                check("ack", isRef, ack_n);
            end
            @(negedge core_clk);
            n++;
        end
        check("busy low", 40, n);
        check("done", !isRef, cpuDone);
        check("kind", isRef, memCycleRefresh);
        if (!isRef)
            check("release", 1, cycle_request_n);
        rowSeen = memRowAddr;
    endtask
    // ==========================================
    // scenarios
    task automatic test_reset();
        check("busy idle", 1, busy);
        check("request idle", 1, cycle_request_n);
        check("burst idle", 0, burstActive);
    endtask
    task automatic test_sys(input dra_addr_t a);
        issue(a);
        @(negedge core_clk);
        row = ~mem_addr_out_n;
        check("pass address", a, row);
        check("ready", 0, cpuReady);
        run_cycle(1'b0, row);
        check("row", a, row);
    endtask
    task automatic test_oscillator();
        @(posedge core_clk);
        refreshInternal <= 1'b1;
        run_cycle(1'b1, prev);
        check("latch fed back", refresh_latch_n, refresh_request_n);
        run_cycle(1'b1, row);
        prev = prev + 6'h1;
        check("next row", prev, row);
        @(posedge core_clk);
        refreshInternal <= 1'b0;
    endtask
    task automatic test_burst();
        int n;
        n = 0;
        while (burstActive !== 1'b1 && n < 6000) begin
            @(negedge core_clk);
            n++;
        end
        // system request lands while the burst holds the arbiter
        issue(6'h2a);
        run_cycle(1'b1, prev);
        for (n = 1; n < 64; n++) begin
            run_cycle(1'b1, row);
            prev = prev + 6'h1;
            check("burst row", prev, row);
        end
        check("burst over", 0, burstActive);
        run_cycle(1'b0, row);
        check("held request", 6'h2a, row);
    endtask
    initial begin
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        @(negedge core_clk);
        test_reset();
        test_sys(6'h3f);
        test_sys(6'h15);
        test_oscillator();
        test_burst();
        give_verdict();
    end
    initial begin
        repeat (40000) @(posedge core_clk);
        fail_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
